// >>> logic/dsbw_pkg.sv
package dsbw_pkg;

	localparam int ADDR_W     = 20;
	localparam int LANE_W     = 9;
	localparam int MAX_LANES  = 4;
	localparam int LANES_X18  = 2;
	localparam int FIFO_DEPTH = 4;
	localparam int MEM_AW     = 8;

	localparam logic [ADDR_W-1:0] BURST_STEP = 20'h00001;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h00000;

	typedef struct packed
	{
		logic [ADDR_W-1:0]           addr;
		logic [MAX_LANES*LANE_W-1:0] data;
		logic [MAX_LANES-1:0]        sel_n;
	} dsbw_beat_type;

	typedef enum logic [2:0]
	{
		RD_IDLE,
		RD_WAIT1,
		RD_WAIT2,
		RD_BEAT0,
		RD_BEAT1,
		RD_TAIL
	} dsbw_rd_state_type;

endpackage : dsbw_pkg

// >>> logic/dsbw_top.sv
`timescale 1ns/1ps

// ****************************************************************
// Beat buffer
// ****************************************************************
module dsbw_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
)
(
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             ce,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PW:0]      wr_ptr;
	logic [PW:0]      rd_ptr;
	logic [PW:0]      next_wr_ptr;
	logic [PW:0]      next_rd_ptr;
	logic             push;
	logic             pop;

	always_comb
	begin
		in_ready    = (wr_ptr[PW-1:0] != rd_ptr[PW-1:0])
			|| (wr_ptr[PW] == rd_ptr[PW]);
		out_valid   = wr_ptr != rd_ptr;
		out_data    = store[rd_ptr[PW-1:0]];
		push        = in_valid && in_ready;
		pop         = out_valid && out_ready;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else if (ce)
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			if (push)
				store[wr_ptr[PW-1:0]] <= in_data;
		end
	end
endmodule : dsbw_fifo

// ****************************************************************
// Byte-masked write path and two-beat read path
// ****************************************************************
module dsbw_top
#(
	parameter int LANES  = dsbw_pkg::LANES_X18,
	parameter int MEM_AW = dsbw_pkg::MEM_AW
)
(
	input  wire logic                              clk,
	input  wire logic                              reset,
	input  wire logic                              ce,
	input  wire logic                              k,
	input  wire logic                              k_n,
	input  wire logic                              load_strobe_n,
	input  wire logic                              read_not_write,
	input  wire logic [dsbw_pkg::ADDR_W-1:0]       addr,
	input  wire logic [LANES*dsbw_pkg::LANE_W-1:0] dq_in,
	input  wire logic [LANES-1:0]                  lane_write_select_n,
	output logic      [LANES*dsbw_pkg::LANE_W-1:0] dq_out,
	output logic                                   dq_oe_n,
	output logic                                   write_overrun
);
	localparam int LW   = dsbw_pkg::LANE_W;
	localparam int DW   = LANES * LW;
	localparam int PADW = (dsbw_pkg::MAX_LANES - LANES) * LW;
	localparam int PADS = dsbw_pkg::MAX_LANES - LANES;

	logic                        k_prev;
	logic                        kn_prev;
	logic                        k_rise;
	logic                        kn_rise;
	logic                        wr_cmd;
	logic                        rd_cmd;
	logic                        pend0;
	logic                        pend1;
	logic                        next_pend0;
	logic                        next_pend1;
	logic [dsbw_pkg::ADDR_W-1:0] addr0;
	logic [dsbw_pkg::ADDR_W-1:0] addr1;
	logic [dsbw_pkg::ADDR_W-1:0] next_addr0;
	logic [dsbw_pkg::ADDR_W-1:0] next_addr1;
	dsbw_pkg::dsbw_beat_type     beat_in;
	dsbw_pkg::dsbw_beat_type     beat_out;
	logic                        push;
	logic                        in_ready;
	logic                        out_valid;
	logic                        out_ready;
	logic                        next_write_overrun;
	dsbw_pkg::dsbw_rd_state_type rd_state;
	dsbw_pkg::dsbw_rd_state_type next_rd_state;
	logic [dsbw_pkg::ADDR_W-1:0] rd_addr;
	logic [dsbw_pkg::ADDR_W-1:0] next_rd_addr;
	logic [dsbw_pkg::ADDR_W-1:0] rd_index;
	logic [DW-1:0]               rd_word;
	logic [DW-1:0]               next_dq_out;
	logic                        next_dq_oe_n;

	// ************************************************************
	// Command and beat capture
	// ************************************************************
	always_comb
	begin
		k_rise  = k && !k_prev;
		kn_rise = k_n && !kn_prev;
		// A read occupies the pins through its tail; commands given meanwhile are dropped
		wr_cmd = k_rise && !load_strobe_n && !read_not_write
			&& rd_state == dsbw_pkg::RD_IDLE;
		rd_cmd = k_rise && !load_strobe_n && read_not_write
			&& rd_state == dsbw_pkg::RD_IDLE && !pend0 && !pend1;
		next_pend0 = pend0;
		next_pend1 = pend1;
		next_addr0 = addr0;
		next_addr1 = addr1;
		beat_in    = '0;
		push       = 1'b0;
		if (k_rise && pend0)
		begin
			// First beat on k to address A, with its own selects
			beat_in.addr  = addr0;
			beat_in.data  = {{PADW{1'b0}}, dq_in};
			beat_in.sel_n = {{PADS{1'b1}}, lane_write_select_n};
			push          = 1'b1;
			next_addr1    = addr0;
			next_pend1    = 1'b1;
			next_pend0    = 1'b0;
		end
		else if (kn_rise && pend1)
		begin
			// Second beat on k_n to A plus one
			beat_in.addr  = addr1 + dsbw_pkg::BURST_STEP;
			beat_in.data  = {{PADW{1'b0}}, dq_in};
			beat_in.sel_n = {{PADS{1'b1}}, lane_write_select_n};
			push          = 1'b1;
			next_pend1    = 1'b0;
		end
		// Without a pending beat the data pins are not looked at
		if (wr_cmd)
		begin
			next_addr0 = addr;
			next_pend0 = 1'b1;
		end
		next_write_overrun = write_overrun || (push && !in_ready);
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			k_prev        <= 1'b1;
			kn_prev       <= 1'b1;
			pend0         <= 1'b0;
			pend1         <= 1'b0;
			addr0         <= dsbw_pkg::ADDR_RESET;
			addr1         <= dsbw_pkg::ADDR_RESET;
			write_overrun <= 1'b0;
		end
		else if (ce)
		begin
			k_prev        <= k;
			kn_prev       <= k_n;
			pend0         <= next_pend0;
			pend1         <= next_pend1;
			addr0         <= next_addr0;
			addr1         <= next_addr1;
			write_overrun <= next_write_overrun;
		end
	end

	// Array port is shared with reads, so draining pauses then
	assign out_ready = rd_state == dsbw_pkg::RD_IDLE;

	dsbw_fifo
	#(
		.WIDTH ($bits(dsbw_pkg::dsbw_beat_type)),
		.DEPTH (dsbw_pkg::FIFO_DEPTH)
	)
	u_fifo
	(
		.clk       (clk),
		.reset     (reset),
		.ce        (ce),
		.in_valid  (push),
		.in_ready  (in_ready),
		.in_data   (beat_in),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (beat_out)
	);

	// ************************************************************
	// Per-lane array
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < LANES; gi++)
		begin : gen_lane
			logic [LW-1:0] mem [2**MEM_AW];
			logic [LW-1:0] rd_q;
			logic          we;
			// Low select writes its lane; all high writes none
			assign we = out_valid && out_ready
				&& !beat_out.sel_n[gi];
			always_ff @(posedge clk)
			begin
				if (ce)
				begin
					if (we)
						mem[beat_out.addr[MEM_AW-1:0]]
							<= beat_out.data[gi*LW +: LW];
					rd_q <= mem[rd_index[MEM_AW-1:0]];
				end
			end
			assign rd_word[gi*LW +: LW] = rd_q;
		end
	endgenerate

	// ************************************************************
	// Read output timing
	// ************************************************************
	always_comb
	begin
		next_rd_state = rd_state;
		next_rd_addr  = rd_addr;
		next_dq_out   = dq_out;
		next_dq_oe_n  = dq_oe_n;
		rd_index      = rd_addr;
		if (rd_state == dsbw_pkg::RD_BEAT1 || rd_state == dsbw_pkg::RD_TAIL
			|| (rd_state == dsbw_pkg::RD_BEAT0 && kn_rise))
			rd_index = rd_addr + dsbw_pkg::BURST_STEP;
		case (rd_state)
			dsbw_pkg::RD_IDLE:
				if (rd_cmd)
				begin
					next_rd_addr  = addr;
					next_rd_state = dsbw_pkg::RD_WAIT1;
				end
			dsbw_pkg::RD_WAIT1:
				if (k_rise)
					next_rd_state = dsbw_pkg::RD_WAIT2;
			dsbw_pkg::RD_WAIT2:
				if (k_rise)
					next_rd_state = dsbw_pkg::RD_BEAT0;
			dsbw_pkg::RD_BEAT0:
				if (kn_rise)
				begin
					next_dq_out   = rd_word;
					next_dq_oe_n  = 1'b0;
					next_rd_state = dsbw_pkg::RD_BEAT1;
				end
			dsbw_pkg::RD_BEAT1:
				if (k_rise)
				begin
					next_dq_out   = rd_word;
					next_rd_state = dsbw_pkg::RD_TAIL;
				end
			dsbw_pkg::RD_TAIL:
				if (kn_rise)
				begin
					next_dq_oe_n  = 1'b1;
					next_rd_state = dsbw_pkg::RD_IDLE;
				end
			default:
				next_rd_state = dsbw_pkg::RD_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rd_state <= dsbw_pkg::RD_IDLE;
			rd_addr  <= dsbw_pkg::ADDR_RESET;
			dq_out   <= '0;
			dq_oe_n  <= 1'b1;
		end
		else if (ce)
		begin
			rd_state <= next_rd_state;
			rd_addr  <= next_rd_addr;
			dq_out   <= next_dq_out;
			dq_oe_n  <= next_dq_oe_n;
		end
	end
endmodule : dsbw_top

// >>> sim/dsbw_monitor.sv
`timescale 1ns/1ps

// ****************************************************************
// Port timing checker
// ****************************************************************
module dsbw_monitor
#(
	parameter int LANES = dsbw_pkg::LANES_X18,
	parameter int MEM_AW = dsbw_pkg::MEM_AW,
	localparam int W = LANES*dsbw_pkg::LANE_W
)
(
	input wire logic			clk,
	input wire logic			reset,
	input wire logic			ce,
	input wire logic			k,
	input wire logic			k_n,
	input wire logic			load_strobe_n,
	input wire logic			read_not_write,
	input wire logic [dsbw_pkg::ADDR_W-1:0]	addr,
	input wire logic [W-1:0]		dq_in,
	input wire logic [LANES-1:0]		lane_write_select_n,
	input wire logic [W-1:0]		dq_out,
	input wire logic			dq_oe_n,
	input wire logic			write_overrun
);
	logic	k_q;
	logic	kn_q;
	logic	k_rise;
	logic	kn_rise;

	// Same edge rule as the block: level seen on clk, parked high at reset
	assign k_rise = ce & k & ~k_q;
	assign kn_rise = ce & k_n & ~kn_q;
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			k_q <= 1'b1;
			kn_q <= 1'b1;
		end
		else if (ce)
		begin
			k_q <= k;
			kn_q <= k_n;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	reset_oe_a: assert property (disable iff (1'b0) reset |=> dq_oe_n)
		else $error("output enable on after reset");
	reset_flag_a: assert property (disable iff (1'b0) reset |=> !write_overrun)
		else $error("overrun set after reset");
	flag_sticky_a: assert property (write_overrun |=> write_overrun)
		else $error("overrun flag cleared");
	oe_on_a: assert property ($fell(dq_oe_n) |-> $past(kn_rise))
		else $error("output enable not on a k_n rise");
	oe_off_a: assert property ($rose(dq_oe_n) |-> $past(kn_rise))
		else $error("output release not on a k_n rise");
	q_edge_a: assert property (!$stable(dq_out) |-> $past(k_rise || kn_rise))
		else $error("read data changed off a clock rise");
	oe_bound_a: assert property ($fell(dq_oe_n) |-> ##[1:64] dq_oe_n)
		else $error("outputs not released");
	ce_freeze_a: assert property (!ce |=> $stable(dq_out) && $stable(dq_oe_n))
		else $error("outputs moved with ce low");

	cover property ($fell(dq_oe_n));
	cover property (kn_rise && lane_write_select_n == '0);
	cover property (!ce);
endmodule : dsbw_monitor

bind dsbw_top dsbw_monitor #(.LANES(LANES), .MEM_AW(MEM_AW)) i_dsbw_monitor
(
	.clk(clk), .reset(reset), .ce(ce), .k(k), .k_n(k_n),
	.load_strobe_n(load_strobe_n), .read_not_write(read_not_write),
	.addr(addr), .dq_in(dq_in), .lane_write_select_n(lane_write_select_n),
	.dq_out(dq_out), .dq_oe_n(dq_oe_n), .write_overrun(write_overrun)
);

// >>> sim/dsbw_ctrl_model.sv
`timescale 1ns/1ps

// ****************************************************************
// Memory controller model
// ****************************************************************
module dsbw_ctrl_model
#(
	parameter int LANES = dsbw_pkg::LANES_X18,
	localparam int W = LANES*dsbw_pkg::LANE_W,
	localparam int AW = dsbw_pkg::ADDR_W
)
(
	input wire logic		clk,
	input wire logic [W-1:0]	dq_out,
	input wire logic		dq_oe_n,
	output logic			k,
	output logic			k_n,
	output logic			load_strobe_n,
	output logic			read_not_write,
	output logic [AW-1:0]		addr,
	output logic [W-1:0]		dq_in,
	output logic [LANES-1:0]	lane_write_select_n
);
	// Clocks park high when stopped, for the quickest restart
	initial
	begin
		k = 1'b1;
		k_n = 1'b1;
		load_strobe_n = 1'b1;
		read_not_write = 1'b1;
		addr = '0;
		dq_in = '0;
		lane_write_select_n = '1;
	end

	// One half period: everything moves at the falling clk edge
	task automatic step(input logic kv, knv, input logic [1:0] c,
		input logic [AW-1:0] a, input logic [W-1:0] d,
		input logic [LANES-1:0] s);
		@(negedge clk);
		k = kv;
		k_n = knv;
		load_strobe_n = c[1];
		read_not_write = c[0];
		addr = a;
		dq_in = d;
		lane_write_select_n = s;
		@(posedge clk);
		#1;
	endtask : step

	// Released lines carry the inverse so a stale value cannot pass
	task automatic write_burst(input logic [AW-1:0] a,
		input logic [W-1:0] d0, d1, input logic [LANES-1:0] s0, s1);
		step('0, '1, 2'b11, ~a, ~d0, ~s0);
		step('1, '0, 2'b00, a, ~d0, ~s0);
		step('0, '0, 2'b11, ~a, ~d0, ~s0);
		step('1, '0, 2'b11, ~a, d0, s0);
		step('1, '1, 2'b11, ~a, d1, s1);
		step('1, '1, 2'b11, ~a, ~d1, ~s1);
	endtask : write_burst

	// Idle first so the write buffer drains; reads do not see it
	task automatic read_burst(input logic [AW-1:0] a,
		output logic [W-1:0] q0, q1, output logic oe0, oe1);
		repeat (4) step('1, '1, 2'b11, ~a, dq_in, lane_write_select_n);
		step('0, '1, 2'b11, ~a, dq_in, lane_write_select_n);
		step('1, '0, 2'b01, a, dq_in, lane_write_select_n);
		repeat (2)
		begin
			step('0, '1, 2'b11, ~a, dq_in, lane_write_select_n);
			step('1, '0, 2'b11, ~a, dq_in, lane_write_select_n);
		end
		step('0, '1, 2'b11, ~a, dq_in, lane_write_select_n);
		q0 = dq_out;
		oe0 = dq_oe_n;
		step('1, '0, 2'b11, ~a, dq_in, lane_write_select_n);
		q1 = dq_out;
		step('0, '1, 2'b11, ~a, dq_in, lane_write_select_n);
		oe1 = dq_oe_n;
		repeat (3) step('1, '1, 2'b11, ~a, dq_in, lane_write_select_n);
	endtask : read_burst
endmodule : dsbw_ctrl_model

// >>> sim/testbench.sv
`timescale 1ns/1ps

// ****************************************************************
// Bench for the 36-bit organisation
// ****************************************************************
module testbench;
	localparam int L = dsbw_pkg::LANE_W;
	localparam int W = 4*L;
	logic				clk = 1'b0;
	logic				reset = 1'b1;
	logic				ce = 1'b1;
	logic				k;
	logic				k_n;
	logic				load_strobe_n;
	logic				read_not_write;
	logic [dsbw_pkg::ADDR_W-1:0]	addr;
	logic [W-1:0]			dq_in;
	logic [3:0]			sel_n;
	logic [W-1:0]			dq_out;
	logic				dq_oe_n;
	logic				write_overrun;
	int				num_errors = 0;
	int				checks_done = 0;

	always #50 clk = ~clk;

	dsbw_top #(.LANES(4)) i_dsbw_top
	(
		.clk(clk), .reset(reset), .ce(ce), .k(k), .k_n(k_n),
		.load_strobe_n(load_strobe_n), .read_not_write(read_not_write),
		.addr(addr), .dq_in(dq_in), .lane_write_select_n(sel_n),
		.dq_out(dq_out), .dq_oe_n(dq_oe_n), .write_overrun(write_overrun)
	);
	dsbw_ctrl_model #(.LANES(4)) i_dsbw_ctrl_model
	(
		.clk(clk), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .k(k), .k_n(k_n),
		.load_strobe_n(load_strobe_n), .read_not_write(read_not_write),
		.addr(addr), .dq_in(dq_in), .lane_write_select_n(sel_n)
	);

	task automatic check(input string n, input logic [W-1:0] e, g);
		checks_done++;
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", n, e, g);
			num_errors++;
		end
	endtask : check

	function automatic logic [W-1:0] merge(logic [W-1:0] o, n, logic [3:0] s);
		merge = o;
		for (int i = 0; i < 4; i++)
			if (!s[i])
				merge[i*L +: L] = n[i*L +: L];
	endfunction : merge

	task automatic read_chk(input logic [19:0] a, input logic [W-1:0] e0, e1);
		logic [W-1:0]	q0;
		logic [W-1:0]	q1;
		logic		oe0;
		logic		oe1;
		i_dsbw_ctrl_model.read_burst(a, q0, q1, oe0, oe1);
		check("word_a", e0, q0);
		check("word_a1", e1, q1);
		check("oe_on", '0, oe0);
		check("oe_off", 36'h000000001, oe1);
	endtask : read_chk

	// Full write across the top of the address space
	task automatic test_wrap;
		i_dsbw_ctrl_model.write_burst(20'hfffff, 36'h123456789, 36'h0fedcba98, '0, '0);
		read_chk(20'hfffff, 36'h123456789, 36'h0fedcba98);
		$display("test_wrap done");
	endtask : test_wrap

	// Masked write straight after a full one; i of 4 selects no lane
	task automatic test_lanes;
		logic [3:0]	s0;
		logic [3:0]	s1;
		for (int i = 0; i < 5; i++)
		begin
			s0 = ~(4'h1 << i);
			s1 = ~(4'h8 >> i);
			i_dsbw_ctrl_model.write_burst(20'h10, 36'h0aaaaaaaa,
				36'h155555555, '0, '0);
			i_dsbw_ctrl_model.write_burst(20'h10, 36'h0c3c3c3c3, 36'h03c3c3c3c, s0, s1);
			read_chk(20'h10, merge(36'h0aaaaaaaa, 36'h0c3c3c3c3, s0), merge(36'h155555555, 36'h03c3c3c3c, s1));
		end
		$display("test_lanes done");
	endtask : test_lanes

	// Clock edges without a command, lanes selected and data swinging
	task automatic test_ignore;
		i_dsbw_ctrl_model.write_burst(20'h20, 36'h011223344, 36'h055667788, '0, '0);
		i_dsbw_ctrl_model.step('0, '0, 2'b11, 20'h20, 36'h0ffffffff, '0);
		i_dsbw_ctrl_model.step('1, '0, 2'b11, 20'h20, 36'h000000000, '0);
		i_dsbw_ctrl_model.step('1, '1, 2'b11, 20'h20, 36'h0ffffffff, '0);
		read_chk(20'h20, 36'h011223344, 36'h055667788);
		check("overrun", '0, write_overrun);
		$display("test_ignore done");
	endtask : test_ignore

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	initial
	begin
		#1000000;
		num_errors++;
		$display("BAD watchdog expected done seen hang");
		print_verdict;
	end

	initial
	begin
		repeat (12) @(negedge clk);
		reset = 1'b0;
		check("oe_idle", 36'h000000001, dq_oe_n);
		check("overrun", '0, write_overrun);
		ce = 1'b0;
		repeat (3) @(negedge clk);
		ce = 1'b1;
		test_wrap;
		test_lanes;
		test_ignore;
		print_verdict;
	end
endmodule : testbench
